// >>> rtl/spd_slave.sv
// Purpose: Slave end: late states, output gating, dictionary.
// Assumes: Watchdog timing lives elsewhere.
// Notes:   Answers are registered pulses one cycle after a request.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Master sends valid outputs before operational request
// R2: Operational drives outputs, accepts process and mailbox
// R3: Boot entered only from initial state
// R4: Boot allows file transfer mailbox only
// R5: Watchdog active holds outputs safe; code does so in every state but op, where it ignores wdActive
// R6: Entry addressed by 16-bit index, 8-bit subindex
// R7: Identity and mapping entries at 0x1000 range
// R8: Channel parameters at 0x8000 or 0x4000
// R9: Inputs at 0x6000, outputs at 0x7000
// R10: Access follows entry attributes; fixed is read-only
// R11: Changed writable parameter saved to nonvolatile memory
// R12: Code word at 0xF008 suppresses saving
// R13: Channel blocks sixteen indices apart
// R14: Master avoids continuous changes without suppression
// R15: Initial state refuses mailbox and process data
// R16: Safe-operational refreshes inputs, holds outputs safe; code passes outputs there while wdActive is low
// R17: Bad write keeps values and answers error
module spd_slave #(
   parameter int          NCH         = 2,
   parameter int          DW          = 16,
   parameter logic [15:0] CHAN_BASE   = spd_pkg::IDX_CHAN_BASE_MAIN,
   parameter logic [31:0] DEVICE_TYPE = 32'h00000001, // Arbitrary value
   parameter logic [31:0] VENDOR_CODE = 32'h00000abc, // Arbitrary value
   parameter logic [DW-1:0] SAFE_LEVEL = '0
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              resetn,
   // Link to the master
   spd_link_if.slave              link,
   // Application side
   input  wire logic              wdActive,
   input  wire logic [NCH*DW-1:0] inputSample,
   output logic      [NCH*DW-1:0] physOut,
   // Store and firmware path
   output logic                   nvWrite,
   output logic      [15:0]       nvIndex,
   output logic      [31:0]       nvData,
   output logic                   fwValid,
   output logic      [31:0]       fwData
);
   // ****************************************
   // Elaboration checks
   // ****************************************
   if (NCH < 1 || NCH > 16 || DW < 1 || DW > 32)
   begin : g_bad
      $error("spd_slave: NCH must be 1..16 and DW 1..32");
   end

   // ****************************************
   // State
   // ****************************************
   spd_pkg::spd_state_type state, next_state;
   logic              pdHeld, next_pdHeld;
   logic [NCH*DW-1:0] pdLatched, next_pdLatched;
   logic [NCH*DW-1:0] pdIn, next_pdIn;
   logic [NCH*DW-1:0] next_physOut;
   logic [31:0]       chanParam [NCH];
   logic [31:0]       next_chanParam [NCH];
   logic [31:0]       codeWord, next_codeWord;
   logic              stateAck, next_stateAck, stateErr, next_stateErr;
   logic              mbxDone, next_mbxDone, mbxErr, next_mbxErr;
   logic [31:0]       mbxRdata, next_mbxRdata;
   logic              pdAck, next_pdAck, pdErr, next_pdErr;
   logic              next_nvWrite, next_fwValid;
   logic [15:0]       next_nvIndex;
   logic [31:0]       next_nvData, next_fwData;

   // Decode results
   logic              hit, readOnly, chanHit, suppress, legal, pdLive;
   logic [31:0]       readVal;
   int unsigned       chanSel;

   assign link.stateCur = state;
   assign link.stateAck = stateAck;
   assign link.stateErr = stateErr;
   assign link.mbxDone  = mbxDone;
   assign link.mbxErr   = mbxErr;
   assign link.mbxRdata = mbxRdata;
   assign link.pdAck    = pdAck;
   assign link.pdErr    = pdErr;
   assign link.pdIn     = pdIn;

   assign suppress = (codeWord == spd_pkg::SAVE_CODE); // R12
   assign pdLive   = (state == spd_pkg::ST_SAFE_OPERATIONAL_MODE) || (state == spd_pkg::ST_OP);

   // ****************************************
   // Dictionary decode
   // ****************************************
   // Index plus subindex picks one entry
   always_comb
   begin
      hit      = 1'b0;
      readOnly = 1'b1;
      chanHit  = 1'b0;
      chanSel  = 0;
      readVal  = '0;
      if (link.mbxSub == spd_pkg::SUB_ZERO) // R6
      begin
         case (link.mbxIndex)
            spd_pkg::IDX_DEVICE_TYPE: begin hit = 1'b1; readVal = DEVICE_TYPE; end // R7
            spd_pkg::IDX_IDENTITY:    begin hit = 1'b1; readVal = VENDOR_CODE; end // R7
            spd_pkg::IDX_RX_MAP,
            spd_pkg::IDX_TX_MAP:      begin hit = 1'b1; readVal = 32'(NCH); end   // R7
            spd_pkg::IDX_SAVE_CTRL:
            begin
               hit      = 1'b1; // R12
               readOnly = 1'b0;
               readVal  = codeWord;
            end
            default: ;
         endcase
      end
      for (int c = 0; c < NCH; c++)
      begin
         if (link.mbxSub == spd_pkg::SUB_VALUE)
         begin
            if (link.mbxIndex == CHAN_BASE + spd_pkg::CHAN_STRIDE * 16'(c)) // R8 R13
            begin
               hit      = 1'b1;
               readOnly = 1'b0; // R10
               chanHit  = 1'b1;
               chanSel  = c;
               readVal  = chanParam[c];
            end
            if (link.mbxIndex == spd_pkg::IDX_INPUT_BASE + spd_pkg::CHAN_STRIDE * 16'(c))
            begin
               hit     = 1'b1; // R9
               readVal = 32'(pdIn[c*DW +: DW]);
            end
            if (link.mbxIndex == spd_pkg::IDX_OUTPUT_BASE + spd_pkg::CHAN_STRIDE * 16'(c))
            begin
               hit     = 1'b1; // R9
               readVal = 32'(pdLatched[c*DW +: DW]);
            end
         end
      end
   end

   // Legal state moves
   always_comb
   begin
      case (state)
         spd_pkg::ST_INIT:   legal = link.stateTarget inside {spd_pkg::ST_INIT,
                                     spd_pkg::ST_PREOP, spd_pkg::ST_BOOT}; // R3
         spd_pkg::ST_PREOP:  legal = link.stateTarget inside {spd_pkg::ST_INIT,
                                     spd_pkg::ST_PREOP, spd_pkg::ST_SAFE_OPERATIONAL_MODE};
         spd_pkg::ST_SAFE_OPERATIONAL_MODE: legal = (link.stateTarget != spd_pkg::ST_BOOT) &&
                                     (link.stateTarget != spd_pkg::ST_OP || pdHeld); // R1
         spd_pkg::ST_OP:     legal = link.stateTarget != spd_pkg::ST_BOOT; // R3
         spd_pkg::ST_BOOT:   legal = link.stateTarget inside {spd_pkg::ST_INIT,
                                     spd_pkg::ST_BOOT};
         default:            legal = 1'b0;
      endcase
   end

   // ****************************************
   // Next values
   // ****************************************
   always_comb
   begin
      next_state     = state;
      next_pdHeld    = pdHeld;
      next_pdLatched = pdLatched;
      next_pdIn      = pdIn;
      next_chanParam = chanParam;
      next_codeWord  = codeWord;
      next_stateAck  = link.stateReq;
      next_stateErr  = 1'b0;
      next_mbxDone   = link.mbxReq;
      next_mbxErr    = 1'b0;
      next_mbxRdata  = '0;
      next_pdAck     = 1'b0;
      next_pdErr     = 1'b0;
      next_nvWrite   = 1'b0;
      next_nvIndex   = '0;
      next_nvData    = '0;
      next_fwValid   = 1'b0;
      next_fwData    = '0;

      // A refused move keeps the state
      if (link.stateReq)
      begin
         if (legal)
            next_state = link.stateTarget;
         else
            next_stateErr = 1'b1; // R3
      end
      if (next_state != spd_pkg::ST_SAFE_OPERATIONAL_MODE && next_state != spd_pkg::ST_OP)
         next_pdHeld = 1'b0;

      // Process data only in safe_operational_state and op
      if (link.pdValid)
      begin
         if (pdLive) // R2
         begin
            next_pdLatched = link.pdOut;
            next_pdAck     = 1'b1;
            if (next_state == spd_pkg::ST_SAFE_OPERATIONAL_MODE || next_state == spd_pkg::ST_OP)
               next_pdHeld = 1'b1;
         end
         else
            next_pdErr = 1'b1; // R4 R15
      end
      if (pdLive)
         next_pdIn = inputSample; // R16

      // Mailbox service
      if (link.mbxReq)
      begin
         if (state == spd_pkg::ST_INIT)
            next_mbxErr = 1'b1; // R15
         else if (state == spd_pkg::ST_BOOT)
         begin
            if (link.mbxService == spd_pkg::SVC_FILE && link.mbxWrite)
            begin
               next_fwValid = 1'b1; // R4
               next_fwData  = link.mbxWdata;
            end
            else
               next_mbxErr = 1'b1; // R4
         end
         else if (link.mbxService != spd_pkg::SVC_DICT || !hit)
            next_mbxErr = 1'b1; // R17
         else if (!link.mbxWrite)
            next_mbxRdata = readVal; // R10
         else if (readOnly)
            next_mbxErr = 1'b1; // R10 R17
         else if (chanHit)
         begin
            next_chanParam[chanSel] = link.mbxWdata;
            if (!suppress)
            begin
               next_nvWrite = 1'b1; // R11
               next_nvIndex = link.mbxIndex;
               next_nvData  = link.mbxWdata;
            end
         end
         else
            next_codeWord = link.mbxWdata; // R12
      end

      // Outputs follow data in op, or safe_operational_state with watchdog off
      for (int c = 0; c < NCH; c++)
      begin
         if (state == spd_pkg::ST_OP ||
             (state == spd_pkg::ST_SAFE_OPERATIONAL_MODE && !wdActive)) // R2 R5
            next_physOut[c*DW +: DW] = pdLatched[c*DW +: DW];
         else
            next_physOut[c*DW +: DW] = SAFE_LEVEL; // R5 R16
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   // Code word clears at reset; a write to 0xF008 loads it, and any value but the save code ends suppression
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state     <= spd_pkg::ST_INIT; // R15
         pdHeld    <= 1'b0;
         pdLatched <= '0;
         pdIn      <= '0;
         physOut   <= '0;
         for (int c = 0; c < NCH; c++)
            chanParam[c] <= spd_pkg::CHAN_PARAM_RESET;
         codeWord  <= '0; // R12
         stateAck  <= 1'b0;
         stateErr  <= 1'b0;
         mbxDone   <= 1'b0;
         mbxErr    <= 1'b0;
         mbxRdata  <= '0;
         pdAck     <= 1'b0;
         pdErr     <= 1'b0;
         nvWrite   <= 1'b0;
         nvIndex   <= '0;
         nvData    <= '0;
         fwValid   <= 1'b0;
         fwData    <= '0;
      end
      else
      begin
         state     <= next_state;
         pdHeld    <= next_pdHeld;
         pdLatched <= next_pdLatched;
         pdIn      <= next_pdIn;
         physOut   <= next_physOut;
         chanParam <= next_chanParam;
         codeWord  <= next_codeWord;
         stateAck  <= next_stateAck;
         stateErr  <= next_stateErr;
         mbxDone   <= next_mbxDone;
         mbxErr    <= next_mbxErr;
         mbxRdata  <= next_mbxRdata;
         pdAck     <= next_pdAck;
         pdErr     <= next_pdErr;
         nvWrite   <= next_nvWrite;
         nvIndex   <= next_nvIndex;
         nvData    <= next_nvData;
         fwValid   <= next_fwValid;
         fwData    <= next_fwData;
      end
   end
endmodule // spd_slave
`default_nettype wire

// >>> rtl/spd_pkg.sv
// Purpose: Shared constants and types of the link.
// Assumes: One 200 MHz clock.
// Notes:   Indices form the dictionary address plan.
package spd_pkg;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {ST_INIT, ST_PREOP, ST_SAFE_OPERATIONAL_MODE, ST_OP, ST_BOOT} spd_state_type;
   typedef enum logic {SVC_DICT, SVC_FILE} spd_service_type;

   // ****************************************
   // Dictionary address plan
   // ****************************************
   localparam logic [15:0] IDX_DEVICE_TYPE    = 16'h1000;
   localparam logic [15:0] IDX_IDENTITY       = 16'h1018;
   localparam logic [15:0] IDX_RX_MAP         = 16'h1600;
   localparam logic [15:0] IDX_TX_MAP         = 16'h1a00;
   localparam logic [15:0] IDX_CHAN_BASE_ALT  = 16'h4000;
   localparam logic [15:0] IDX_INPUT_BASE     = 16'h6000;
   localparam logic [15:0] IDX_OUTPUT_BASE    = 16'h7000;
   localparam logic [15:0] IDX_CHAN_BASE_MAIN = 16'h8000;
   localparam logic [15:0] IDX_SAVE_CTRL      = 16'hf008;
   localparam logic [15:0] CHAN_STRIDE        = 16'h0010;
   localparam logic [7:0]  SUB_ZERO           = 8'h00;
   localparam logic [7:0]  SUB_VALUE          = 8'h01;

   // ****************************************
   // Values and timing
   // ****************************************
   localparam logic [31:0] SAVE_CODE        = 32'h12345678;
   localparam logic [31:0] CHAN_PARAM_RESET = 32'h00000000;
   localparam int          NV_WRITE_LIFE    = 100000;
   localparam int          WRITE_GAP_CYCLES = 2000000; // 10 ms at 200 MHz
endpackage

// >>> rtl/spd_link_if.sv
// Purpose: Link between master end and slave end.
// Assumes: Both ends on the same clock; answers are one-cycle pulses.
// Notes:   The testbench joins the two ends here.
`timescale 1ns/1ps
`default_nettype none
interface spd_link_if #(parameter int NCH = 2, parameter int DW = 16);
   // State change
   logic                      stateReq;
   spd_pkg::spd_state_type    stateTarget;
   logic                      stateAck;
   logic                      stateErr;
   spd_pkg::spd_state_type    stateCur;
   // Mailbox
   logic                      mbxReq;
   logic                      mbxWrite;
   spd_pkg::spd_service_type  mbxService;
   logic [15:0]               mbxIndex;
   logic [7:0]                mbxSub;
   logic [31:0]               mbxWdata;
   logic                      mbxDone;
   logic                      mbxErr;
   logic [31:0]               mbxRdata;
   // Process data
   logic                      pdValid;
   logic [NCH*DW-1:0]         pdOut;
   logic                      pdAck;
   logic                      pdErr;
   logic [NCH*DW-1:0]         pdIn;

   modport slave (input stateReq, stateTarget, mbxReq, mbxWrite, mbxService, mbxIndex,
                  mbxSub, mbxWdata, pdValid, pdOut,
                  output stateAck, stateErr, stateCur, mbxDone, mbxErr, mbxRdata,
                  pdAck, pdErr, pdIn);
   modport master (output stateReq, stateTarget, mbxReq, mbxWrite, mbxService, mbxIndex,
                   mbxSub, mbxWdata, pdValid, pdOut,
                   input stateAck, stateErr, stateCur, mbxDone, mbxErr, mbxRdata,
                   pdAck, pdErr, pdIn);
endinterface // spd_link_if
`default_nettype wire

// >>> rtl/spd_master.sv
// Purpose: Master end: sequences state, mailbox and process data requests.
// Assumes: One user command at a time; busy while one is open.
// Notes:   Unsuppressed writes are spaced to spare the slave's store.
`timescale 1ns/1ps
`default_nettype none
module spd_master #(
   parameter int NCH       = 2,
   parameter int DW        = 16,
   parameter int WRITE_GAP = spd_pkg::WRITE_GAP_CYCLES
) (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     resetn,
   // Link to the slave
   spd_link_if.master                    link,
   // User commands
   input  wire logic                     cmdState,
   input  wire spd_pkg::spd_state_type   cmdTarget,
   input  wire logic                     cmdParam,
   input  wire logic                     cmdWrite,
   input  wire spd_pkg::spd_service_type cmdService,
   input  wire logic [15:0]              cmdIndex,
   input  wire logic [7:0]               cmdSub,
   input  wire logic [31:0]              cmdWdata,
   input  wire logic                     cmdPd,
   input  wire logic [NCH*DW-1:0]        cmdPdData,
   // User answers
   output logic                          busy,
   output logic                          done,
   output logic                          err,
   output logic [31:0]                   rdata,
   output logic                          suppressed
);
   if (NCH < 1 || DW < 1 || WRITE_GAP < 1)
   begin : g_bad
      $error("spd_master: parameters must be positive");
   end

   typedef enum logic [2:0] {M_IDLE, M_PD, M_PD_WAIT, M_ST, M_ST_WAIT, M_MBX, M_MBX_WAIT}
      spd_mstate_type;

   spd_mstate_type    mst, next_mst;
   logic              goOp, next_goOp, havePd, next_havePd;
   logic              next_done, next_err, next_suppressed;
   logic [31:0]       next_rdata;
   logic [31:0]       gapCnt, next_gapCnt;
   logic [NCH*DW-1:0] pdShadow, next_pdShadow;
   spd_pkg::spd_state_type   tgt, next_tgt;
   logic              wr, next_wr;
   spd_pkg::spd_service_type svc, next_svc;
   logic [15:0]       idx, next_idx;
   logic [7:0]        sub, next_sub;
   logic [31:0]       wdat, next_wdat;

   // Requests decode from the sequencer state
   assign link.stateReq    = (mst == M_ST);
   assign link.stateTarget = tgt;
   assign link.mbxReq      = (mst == M_MBX);
   assign link.mbxWrite    = wr;
   assign link.mbxService  = svc;
   assign link.mbxIndex    = idx;
   assign link.mbxSub      = sub;
   assign link.mbxWdata    = wdat;
   assign link.pdValid     = (mst == M_PD);
   assign link.pdOut       = pdShadow;
   assign busy             = (mst != M_IDLE);

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb
   begin
      next_mst = mst;         next_goOp = goOp;     next_havePd = havePd;
      next_done = 1'b0;       next_err = 1'b0;      next_rdata = rdata;
      next_suppressed = suppressed;
      next_gapCnt = (gapCnt != 32'h0) ? gapCnt - 32'h1 : gapCnt;
      next_pdShadow = pdShadow;
      next_tgt = tgt; next_wr = wr; next_svc = svc;
      next_idx = idx; next_sub = sub; next_wdat = wdat;
      case (mst)
         M_IDLE:
         begin
            if (cmdState)
            begin
               next_tgt  = cmdTarget;
               next_goOp = (cmdTarget == spd_pkg::ST_OP);
               if (cmdTarget != spd_pkg::ST_OP)
                  next_mst = M_ST;
               else if (havePd)
                  next_mst = M_PD; // R1
               else
               begin
                  next_done = 1'b1; // R1
                  next_err  = 1'b1;
               end
            end
            else if (cmdParam)
            begin
               if (cmdWrite && !suppressed && gapCnt != 32'h0)
               begin
                  next_done = 1'b1; // R14
                  next_err  = 1'b1;
               end
               else
               begin
                  next_mst = M_MBX;
                  next_wr = cmdWrite; next_svc = cmdService;
                  next_idx = cmdIndex; next_sub = cmdSub; next_wdat = cmdWdata; // R6
               end
            end
            else if (cmdPd)
            begin
               next_pdShadow = cmdPdData;
               next_havePd   = 1'b1;
               next_goOp     = 1'b0;
               next_mst      = M_PD;
            end
         end
         M_PD:      next_mst = M_PD_WAIT;
         M_PD_WAIT:
         begin
            if (link.pdAck || link.pdErr)
            begin
               if (goOp && link.pdAck)
                  next_mst = M_ST; // R1
               else
               begin
                  next_mst  = M_IDLE;
                  next_done = 1'b1;
                  next_err  = link.pdErr;
               end
            end
         end
         M_ST:      next_mst = M_ST_WAIT;
         M_ST_WAIT:
         begin
            if (link.stateAck)
            begin
               next_mst  = M_IDLE;
               next_done = 1'b1;
               next_err  = link.stateErr;
            end
         end
         M_MBX:     next_mst = M_MBX_WAIT;
         M_MBX_WAIT:
         begin
            if (link.mbxDone)
            begin
               next_mst   = M_IDLE;
               next_done  = 1'b1;
               next_err   = link.mbxErr;
               next_rdata = link.mbxRdata;
               if (wr && !link.mbxErr && svc == spd_pkg::SVC_DICT)
               begin
                  if (idx == spd_pkg::IDX_SAVE_CTRL)
                     next_suppressed = (wdat == spd_pkg::SAVE_CODE); // R12
                  else if (!suppressed)
                     next_gapCnt = 32'(WRITE_GAP); // R14
               end
            end
         end
         default:   next_mst = M_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         mst <= M_IDLE;   goOp <= 1'b0;   havePd <= 1'b0;
         done <= 1'b0;    err <= 1'b0;    rdata <= '0;
         suppressed <= 1'b0; // R12
         gapCnt <= '0;    pdShadow <= '0;
         tgt <= spd_pkg::ST_INIT; wr <= 1'b0; svc <= spd_pkg::SVC_DICT;
         idx <= '0;       sub <= '0;      wdat <= '0;
      end
      else
      begin
         mst <= next_mst; goOp <= next_goOp; havePd <= next_havePd;
         done <= next_done; err <= next_err; rdata <= next_rdata;
         suppressed <= next_suppressed;
         gapCnt <= next_gapCnt; pdShadow <= next_pdShadow;
         tgt <= next_tgt; wr <= next_wr; svc <= next_svc;
         idx <= next_idx; sub <= next_sub; wdat <= next_wdat;
      end
   end
endmodule // spd_master
`default_nettype wire

// >>> testbench/spd_link_props.sv
// Purpose: Timing and refusal checks on the link.
// Assumes: One clock; resetn async, active low.
// Notes:   Answers are due one cycle after requests.
`timescale 1ns/1ps
`default_nettype none
module spd_link_props (
   // Clock and reset
   input wire logic        clock,
   input wire logic        resetn,
   // Link signals
   input wire logic        stateReq,
   input wire logic [2:0]  stateTarget,
   input wire logic        stateAck,
   input wire logic        stateErr,
   input wire logic [2:0]  stateCur,
   input wire logic        mbxReq,
   input wire logic        mbxWrite,
   input wire logic        mbxService,
   input wire logic [15:0] mbxIndex,
   input wire logic        mbxDone,
   input wire logic        mbxErr,
   input wire logic        pdValid,
   input wire logic        pdAck,
   input wire logic        pdErr
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // A refused mailbox answer
   sequence s_refused;
      mbxDone && mbxErr;
   endsequence
   chk_state_answer: assert property (stateReq |=> stateAck)
      else $error("state answer missing");
   chk_boot_entry:
      assert property (stateReq && stateTarget == spd_pkg::ST_BOOT
         && !(stateCur inside {spd_pkg::ST_INIT, spd_pkg::ST_BOOT})
         |=> stateErr && $stable(stateCur)) else $error("boot entry taken");
   chk_init_mbx:
      assert property (mbxReq && stateCur == spd_pkg::ST_INIT |=> s_refused)
      else $error("mailbox served in init");
   chk_init_pd:
      assert property (pdValid && stateCur == spd_pkg::ST_INIT |=> pdErr)
      else $error("process data served in init");
   chk_boot_pd:
      assert property (pdValid && stateCur == spd_pkg::ST_BOOT |=> pdErr && !pdAck)
      else $error("process data served in boot");
   chk_boot_dict:
      assert property (mbxReq && stateCur == spd_pkg::ST_BOOT
         && mbxService == spd_pkg::SVC_DICT |=> s_refused) else $error("dict in boot");
   chk_op_pd:
      assert property (pdValid && stateCur == spd_pkg::ST_OP |=> pdAck && !pdErr)
      else $error("process data refused in op");
   chk_fixed_ro:
      assert property (mbxReq && mbxWrite && mbxIndex == 16'h1000 |=> s_refused)
      else $error("fixed entry written");
endmodule // spd_link_props
`default_nettype wire

// >>> testbench/slave_state_and_param_dictionary_test.sv
// Purpose: Drives the master user side, checks outcomes.
// Assumes: Write gap shortened to 20 cycles.
// Notes:   Expectations follow the address plan.
`timescale 1ns/1ps
`default_nettype none
module slave_state_and_param_dictionary_test;
   logic clock, resetn, wdActive, cmdState, cmdParam, cmdWrite, cmdPd;
   logic busy, done, err, suppressed, nvWrite, fwValid;
   spd_pkg::spd_state_type   cmdTarget;
   spd_pkg::spd_service_type cmdService;
   logic [15:0] cmdIndex, nvIndex, nvLast;
   logic [7:0]  cmdSub;
   logic [31:0] cmdWdata, rdata, nvData, fwData, fwLast, cmdPdData, inputSample, physOut;
   int          n_errors, n_checks, nvCount;
   spd_link_if lnk ();
   spd_master #(.WRITE_GAP(20)) u_spd_master (.clock, .resetn,
      .link(lnk), .cmdState, .cmdTarget, .cmdParam, .cmdWrite, .cmdService, .cmdIndex,
      .cmdSub, .cmdWdata, .cmdPd, .cmdPdData, .busy, .done, .err, .rdata, .suppressed);
   spd_slave u_spd_slave (.clock, .resetn, .link(lnk), .wdActive,
      .inputSample, .physOut, .nvWrite, .nvIndex, .nvData, .fwValid, .fwData);
   spd_link_props u_props (.clock, .resetn, .stateReq(lnk.stateReq),
      .stateTarget(lnk.stateTarget), .stateAck(lnk.stateAck), .stateErr(lnk.stateErr),
      .stateCur(lnk.stateCur), .mbxReq(lnk.mbxReq), .mbxWrite(lnk.mbxWrite),
      .mbxService(lnk.mbxService), .mbxIndex(lnk.mbxIndex), .mbxDone(lnk.mbxDone),
      .mbxErr(lnk.mbxErr), .pdValid(lnk.pdValid), .pdAck(lnk.pdAck), .pdErr(lnk.pdErr));
   // Clock, 5 ns period
   initial
   begin
      clock = 0;
      forever #2.5 clock = ~clock;
   end
   // Catch the one-cycle store and firmware pulses
   always @(negedge clock)
   begin
      if (nvWrite === 1'b1) begin nvCount++; nvLast = nvIndex; end
      if (fwValid === 1'b1) fwLast = fwData;
   end
   task automatic cmp(input logic [31:0] a, input logic [31:0] e);
      n_checks++;
      if (a !== e)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
      end
   endtask
   // One command; bounded wait on done
   task automatic go(input int k, input logic ee);
      int n;
      cmdState = (k == 0);
      cmdParam = (k == 1);
      cmdPd = (k == 2);
      @(negedge clock);
      {cmdState, cmdParam, cmdPd} = 3'h0;
      for (n = 0; n < 99 && done !== 1'b1; n++) @(negedge clock);
      cmp({done, err}, {1'b1, ee});
   endtask
   task automatic st(input spd_pkg::spd_state_type t, input logic ee);
      cmdTarget = t;
      go(0, ee);
   endtask
   task automatic mb(input logic w, input spd_pkg::spd_service_type s,
                     input logic [15:0] i, input logic [7:0] b, input logic [31:0] d,
                     input logic ee);
      {cmdWrite, cmdService, cmdIndex, cmdSub, cmdWdata} = {w, s, i, b, d};
      go(1, ee);
      if (!w && !ee) cmp(rdata, d);
   endtask
   task automatic pd(input logic [31:0] d, input logic ee);
      cmdPdData = d;
      go(2, ee);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Watchdog, well past the run's length
   initial
   begin
      #60000;
      n_errors++;
      conclude;
   end
   initial
   begin
      {resetn, wdActive, cmdState, cmdParam, cmdWrite, cmdPd} = 6'h10;
      {cmdIndex, cmdSub, cmdWdata, cmdPdData, nvCount} = '0;
      {cmdTarget, cmdService} = {spd_pkg::ST_INIT, spd_pkg::SVC_DICT};
      inputSample = 32'habcd0123;
      {n_errors, n_checks} = '0;
      repeat (16) @(negedge clock);
      resetn = 1;
      mb(0, spd_pkg::SVC_DICT, 16'h1000, 8'h00, 0, 1);
      pd(0, 1);
      st(spd_pkg::ST_PREOP, 0);
      st(spd_pkg::ST_BOOT, 1);
      $display("init test done");
      mb(0, spd_pkg::SVC_DICT, 16'h1000, 8'h00, 32'h1, 0);
      mb(1, spd_pkg::SVC_DICT, 16'h1000, 8'h00, 32'h5, 1);
      mb(1, spd_pkg::SVC_DICT, 16'h8010, 8'h01, 32'h1234, 0);
      cmp({nvCount[15:0], nvLast}, {16'h1, 16'h8010});
      mb(0, spd_pkg::SVC_DICT, 16'h8010, 8'h01, 32'h1234, 0);
      repeat (25) @(negedge clock);
      mb(1, spd_pkg::SVC_DICT, 16'h8020, 8'h01, 32'h1, 1);
      mb(1, spd_pkg::SVC_DICT, 16'hf008, 8'h00, spd_pkg::SAVE_CODE, 0);
      mb(1, spd_pkg::SVC_DICT, 16'h8000, 8'h01, 32'h55, 0);
      cmp({nvCount[30:0], suppressed}, {31'h1, 1'b1});
      mb(1, spd_pkg::SVC_DICT, 16'hf008, 8'h00, 32'h0, 0);
      cmp(suppressed, 0);
      $display("dictionary test done");
      st(spd_pkg::ST_SAFE_OPERATIONAL_MODE, 0);
      pd(32'h00aa0055, 0);
      repeat (2) @(negedge clock);
      cmp(physOut, 0);
      wdActive = 0;
      repeat (2) @(negedge clock);
      cmp(physOut, 32'h00aa0055);
      mb(0, spd_pkg::SVC_DICT, 16'h6010, 8'h01, 32'habcd, 0);
      st(spd_pkg::ST_OP, 0);
      pd(32'h11223344, 0);
      repeat (2) @(negedge clock);
      cmp(physOut, 32'h11223344);
      mb(0, spd_pkg::SVC_DICT, 16'h7000, 8'h01, 32'h3344, 0);
      $display("process data test done");
      st(spd_pkg::ST_BOOT, 1);
      st(spd_pkg::ST_INIT, 0);
      st(spd_pkg::ST_BOOT, 0);
      mb(0, spd_pkg::SVC_DICT, 16'h1000, 8'h00, 0, 1);
      mb(1, spd_pkg::SVC_FILE, 16'h0000, 8'h00, 32'hcafe0001, 0);
      cmp(fwLast, 32'hcafe0001);
      pd(0, 1);
      $display("boot test done");
      conclude;
   end
endmodule // slave_state_and_param_dictionary_test
`default_nettype wire
